// File: core/sas_pkg.sv
package sas_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 10;
    localparam int RES_W  = 12;
    localparam int SEL_W  = 5;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OPTION   = 10'h094;
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_FLAGS   = 10'h095;
    localparam logic [IDX_W-1:0] IDX_RES_LO   = 10'h0aa;
    localparam logic [IDX_W-1:0] IDX_RES_HI   = 10'h0ab;
    localparam logic [IDX_W-1:0] IDX_CHREF    = 10'h0ae;
    localparam logic [IDX_W-1:0] IDX_AUXILIARY_CONTROL_ONE     = 10'h0f8;
    localparam logic [IDX_W-1:0] IDX_EVT_STAT = 10'h100;
    localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h101;

    localparam logic [7:0] OPTION_RST      = 8'h00;
    localparam logic [7:0] CHREF_RST       = 8'hf8;
    localparam logic [7:0] INTERRUPT_FLAGS_CLR_DONE = 8'hef;

    localparam int DIV_LSB      = 2;
    localparam int DONE_BIT     = 4;
    localparam int START_BIT    = 4;
    localparam int REF_BIT      = 2;
    localparam int CH_LSB       = 3;
    localparam int BG_LSB       = 0;
    localparam int RESLO_LSB    = 4;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_BUSY_BIT = 1;

    localparam logic [5:0] CONV_CYCLES   = 6'd42;
    localparam logic [5:0] SAMPLE_CYCLES = CONV_CYCLES - 6'(2 * RES_W);

    localparam logic [1:0] CKS_32    = 2'b00;
    localparam logic [1:0] CKS_16    = 2'b01;
    localparam logic [1:0] CKS_8     = 2'b10;
    localparam logic [5:0] DIV_BY_32 = 6'd32;
    localparam logic [5:0] DIV_BY_16 = 6'd16;
    localparam logic [5:0] DIV_BY_8  = 6'd8;
    localparam logic [5:0] DIV_BY_4  = 6'd4;

    localparam logic [4:0] CH_HI_LAST  = 5'h15;
    localparam logic [4:0] CH_QSUPPLY  = 5'h17;
    localparam logic [1:0] BG_LOW      = 2'b00;
    localparam logic [1:0] BG_HIGH     = 2'b01;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} sas_state_t;

    function automatic logic [5:0] div_of(input logic [1:0] sel);
        case (sel)
            CKS_32:  div_of = DIV_BY_32;
            CKS_16:  div_of = DIV_BY_16;
            CKS_8:   div_of = DIV_BY_8;
            default: div_of = DIV_BY_4;
        endcase
    endfunction

    // Codes up to 10101 are all routed; 10110 and above 10111 are not
    function automatic logic chan_legal(input logic [SEL_W-1:0] c);
        chan_legal = (c <= CH_HI_LAST) || (c == CH_QSUPPLY);
    endfunction

    function automatic logic reg_mapped(input logic [IDX_W-1:0] i);
        reg_mapped = (i == IDX_OPTION) || (i == IDX_INTERRUPT_FLAGS)
                  || (i == IDX_RES_LO) || (i == IDX_RES_HI)
                  || (i == IDX_CHREF)  || (i == IDX_AUXILIARY_CONTROL_ONE)
                  || (i == IDX_EVT_STAT) || (i == IDX_EVT_MASK);
    endfunction
endpackage

// File: core/sas_conv_seq.sv
`timescale 1ns/100ps
module sas_conv_seq (
    input  wire logic                    aclk,     // System clock
    input  wire logic                    aresetn,  // Sync reset, low
    input  wire logic                    launch,   // Start pulse
    input  wire logic                    abort,    // Stop pulse
    input  wire logic [1:0]              div_sel,  // Divider code
    input  wire logic                    comp,     // Synced comparator
    output logic                         busy,     // Conversion running
    output logic                         conv_clk, // Converter clock
    output logic                         sample,   // Sample-and-hold
    output logic [sas_pkg::RES_W-1:0]    trial,    // SAR trial code
    output logic                         done,     // End pulse
    output logic [sas_pkg::RES_W-1:0]    result    // Final code
);
    import sas_pkg::*;

    sas_state_t       state_q, state_d;
    logic [5:0]       div_q, div_cnt_q, phase_q, phase_n;
    logic [RES_W-1:0] trial_d;
    logic             done_d, tick;
    logic [11:0]      cyc_q;

    function automatic logic [3:0] bit_of(input logic [5:0] p);
        logic [5:0] off;
        off    = p - SAMPLE_CYCLES;
        bit_of = 4'(RES_W - 1) - off[4:1];
    endfunction

    // Divider latched at launch so a mid-conversion change cannot tear it
    assign tick    = (state_q != S_IDLE) && (div_cnt_q == div_q - 6'd1);
    assign phase_n = phase_q + 6'd1;

    always_comb begin
        state_d = state_q;
        trial_d = trial;
        done_d  = 1'b0;
        if (abort) begin
            state_d = S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: if (launch) begin
                    state_d = S_SAMPLE;
                    trial_d = '0;
                end
                S_SAMPLE: if (tick && phase_n == SAMPLE_CYCLES) begin
                    state_d                = S_CONVERT;
                    trial_d[bit_of(phase_n)] = 1'b1;
                end
                S_CONVERT: if (tick) begin
                    // Two converter clocks per bit: try, then decide
                    if (phase_q[0] != SAMPLE_CYCLES[0]) begin
                        trial_d[bit_of(phase_q)] = comp;
                    end
                    if (phase_q == CONV_CYCLES - 6'd1) begin
                        state_d = S_IDLE;
                        done_d  = 1'b1;
                    end else if (phase_n[0] == SAMPLE_CYCLES[0]) begin
                        trial_d[bit_of(phase_n)] = 1'b1;
                    end
                end
                default: state_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            trial   <= '0;
            done    <= 1'b0;
        end else begin
            state_q <= state_d;
            trial   <= trial_d;
            done    <= done_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q     <= DIV_BY_32;
            div_cnt_q <= '0;
            phase_q   <= '0;
        end else if (state_q == S_IDLE && launch) begin
            div_q     <= div_of(div_sel);
            div_cnt_q <= '0;
            phase_q   <= '0;
        end else if (tick) begin
            div_cnt_q <= '0;
            phase_q   <= phase_n;
        end else if (state_q != S_IDLE) begin
            div_cnt_q <= div_cnt_q + 6'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result   <= '0;
            busy     <= 1'b0;
            sample   <= 1'b0;
            conv_clk <= 1'b0;
        end else begin
            if (done_d) begin
                result <= trial_d;
            end
            busy     <= state_d != S_IDLE;
            sample   <= state_d == S_SAMPLE;
            conv_clk <= (state_q != S_IDLE) && (div_cnt_q < (div_q >> 1));
        end
    end

    // Helper count of system cycles since launch
    always_ff @(posedge aclk) begin
        if (!aresetn || (state_q == S_IDLE && launch)) begin
            cyc_q <= '0;
        end else if (state_q != S_IDLE) begin
            cyc_q <= cyc_q + 12'd1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_launch;
        state_q == S_IDLE && launch && !abort;
    endsequence

    a_conv_length:
    assert property (done |-> cyc_q == 12'(CONV_CYCLES) * 12'(div_q))
    else $error("conversion length is not 42 converter clocks");

    a_div_ratio:
    assert property (s_launch |=> div_q == div_of($past(div_sel)))
    else $error("converter clock divider does not follow its code");
endmodule

// File: core/sas_top.sv
`timescale 1ns/100ps
// Operation
// - Converter clock is system clock over 32/16/8/4
// - Writing start bit begins; hardware clears at end
// - Writing zero to start bit clears it
// - Completion sets done flag and interrupt request
// - Done flag cleared by zero write or start
// - Writing EFh clears only the done flag
// - Conversion lasts 42 converter clock cycles
// - High register bits 11..4, low register upper nibble bits 3..0
// - Five-bit channel code routes listed inputs only
// - Reference bit: zero supply, one bandgap
// - Bandgap level: 00 lower, 01 higher, rest reserved
module sas_top (
    input  wire logic                       aclk,            // Clock
    input  wire logic                       aresetn,         // Reset, low
    input  wire logic [sas_pkg::ADDR_W-1:0] awaddr,          // AXI
    input  wire logic                       awvalid,         // AXI
    output logic                            awready,         // AXI
    input  wire logic [sas_pkg::DATA_W-1:0] wdata,           // AXI
    input  wire logic [3:0]                 wstrb,           // AXI
    input  wire logic                       wvalid,          // AXI
    output logic                            wready,          // AXI
    output logic [1:0]                      bresp,           // AXI
    output logic                            bvalid,          // AXI
    input  wire logic                       bready,          // AXI
    input  wire logic [sas_pkg::ADDR_W-1:0] araddr,          // AXI
    input  wire logic                       arvalid,         // AXI
    output logic                            arready,         // AXI
    output logic [sas_pkg::DATA_W-1:0]      rdata,           // AXI
    output logic [1:0]                      rresp,           // AXI
    output logic                            rvalid,          // AXI
    input  wire logic                       rready,          // AXI
    output logic                            irq,             // Level irq
    input  wire logic                       afe_comp,        // Comparator
    output logic                            afe_conv_clk,    // Conv clock
    output logic                            afe_sample,      // Track/hold
    output logic [sas_pkg::RES_W-1:0]       afe_trial,       // SAR code
    output logic [sas_pkg::SEL_W-1:0]       afe_channel,     // Mux code
    output logic                            afe_mux_en,      // Mux on
    output logic                            afe_ref_bandgap, // Ref select
    output logic [1:0]                      afe_bg_level     // Bandgap lvl
);
    import sas_pkg::*;

    logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic              aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0]        wbyte_q;
    logic              wlane_q;
    logic [7:0]        opt_q, chref_q, rd_val;
    logic              start_q, start_d, done_flag_q, done_flag_d;
    logic              evt_q, evt_d, mask_q, comp_s1_q, comp_s2_q;
    logic [RES_W-1:0]  res_q;
    logic              seq_busy, seq_done, seq_clk, seq_sample;
    logic [RES_W-1:0]  seq_trial, seq_result;

    wire do_aw  = awvalid && awready;
    wire do_w   = wvalid && wready;
    wire do_wr  = aw_hold_q && w_hold_q && !bvalid_q;
    wire do_rd  = arvalid && arready;

    wire [IDX_W-1:0] wr_idx = awaddr_q[ADDR_W-1:2];
    wire [IDX_W-1:0] rd_idx = araddr[ADDR_W-1:2];
    wire             wr_en  = do_wr && wlane_q;

    wire we_opt    = wr_en && wr_idx == IDX_OPTION;
    wire we_interrupt_flags = wr_en && wr_idx == IDX_INTERRUPT_FLAGS;
    wire we_chref  = wr_en && wr_idx == IDX_CHREF;
    wire we_aux    = wr_en && wr_idx == IDX_AUXILIARY_CONTROL_ONE;
    wire we_stat   = wr_en && wr_idx == IDX_EVT_STAT;
    wire we_mask   = wr_en && wr_idx == IDX_EVT_MASK;

    wire start_wr1 = we_aux && wbyte_q[START_BIT];
    wire start_wr0 = we_aux && !wbyte_q[START_BIT];
    // A new start may land in the completing cycle itself
    wire launch    = start_wr1 && (!start_q || seq_done);
    wire abort     = start_wr0 && start_q && !seq_done;

    wire flag_clr  = (we_interrupt_flags && !wbyte_q[DONE_BIT]) || launch;
    wire evt_clr   = we_stat && wbyte_q[EVT_DONE_BIT];

    wire [4:0] chan_code = chref_q[CH_LSB +: SEL_W];
    wire [1:0] bg_code   = chref_q[BG_LSB +: 2];

    // Write channel: address and data taken independently, in any order
    assign aw_hold_d = (aw_hold_q || do_aw) && !do_wr;
    assign w_hold_d  = (w_hold_q || do_w) && !do_wr;
    assign bvalid_d  = do_wr || (bvalid_q && !bready);
    assign rvalid_d  = do_rd || (rvalid_q && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            rvalid_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            arready   <= 1'b0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            awready   <= !aw_hold_d;
            wready    <= !w_hold_d;
            arready   <= !rvalid_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= '0;
            wbyte_q  <= '0;
            wlane_q  <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            if (do_aw) begin
                awaddr_q <= awaddr;
            end
            if (do_w) begin
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            if (do_wr) begin
                bresp <= reg_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign rvalid = rvalid_q;

    // Read decode; unused option bits read back as written, other unused bits read as zero
    always_comb begin
        if (rd_idx == IDX_OPTION) begin
            rd_val = opt_q;
        end else if (rd_idx == IDX_INTERRUPT_FLAGS) begin
            rd_val = 8'(done_flag_q) << DONE_BIT;
        end else if (rd_idx == IDX_RES_LO) begin
            rd_val = 8'(res_q[3:0]) << RESLO_LSB;
        end else if (rd_idx == IDX_RES_HI) begin
            rd_val = res_q[RES_W-1:4];
        end else if (rd_idx == IDX_CHREF) begin
            rd_val = chref_q;
        end else if (rd_idx == IDX_AUXILIARY_CONTROL_ONE) begin
            rd_val = 8'(start_q) << START_BIT;
        end else if (rd_idx == IDX_EVT_STAT) begin
            rd_val = (8'(evt_q) << EVT_DONE_BIT)
                   | (8'(seq_busy) << EVT_BUSY_BIT);
        end else if (rd_idx == IDX_EVT_MASK) begin
            rd_val = 8'(mask_q) << EVT_DONE_BIT;
        end else begin
            rd_val = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (do_rd) begin
            rdata <= DATA_W'(rd_val);
            rresp <= reg_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Hardware set wins over any clear in the same cycle
    assign start_d     = start_wr1 ? 1'b1 : (start_wr0 || seq_done)
                       ? 1'b0 : start_q;
    assign done_flag_d = seq_done || (done_flag_q && !flag_clr);
    assign evt_d       = seq_done || (evt_q && !evt_clr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opt_q       <= OPTION_RST;
            chref_q     <= CHREF_RST;
            start_q     <= 1'b0;
            done_flag_q <= 1'b0;
            evt_q       <= 1'b0;
            mask_q      <= 1'b0;
            irq         <= 1'b0;
        end else begin
            if (we_opt) begin
                opt_q <= wbyte_q;
            end
            if (we_chref) begin
                chref_q <= wbyte_q;
            end
            if (we_mask) begin
                mask_q <= wbyte_q[EVT_DONE_BIT];
            end
            start_q     <= start_d;
            done_flag_q <= done_flag_d;
            evt_q       <= evt_d;
            irq         <= evt_d && (we_mask ? wbyte_q[EVT_DONE_BIT]
                                             : mask_q);
        end
    end

    // Results only move on completion, so a read never sees half a code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_q <= '0;
        end else if (seq_done) begin
            res_q <= seq_result;
        end
    end

    // Comparator is asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end else begin
            comp_s1_q <= afe_comp;
            comp_s2_q <= comp_s1_q;
        end
    end

    // Analog selects; reserved codes leave the mux open
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            afe_channel     <= CHREF_RST[CH_LSB +: SEL_W];
            afe_mux_en      <= 1'b0;
            afe_ref_bandgap <= 1'b0;
            afe_bg_level    <= BG_LOW;
        end else begin
            afe_channel     <= chan_code;
            afe_mux_en      <= chan_legal(chan_code);
            afe_ref_bandgap <= chref_q[REF_BIT];
            afe_bg_level    <= (bg_code == BG_HIGH) ? BG_HIGH
                                                    : BG_LOW;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            afe_conv_clk <= 1'b0;
            afe_sample   <= 1'b0;
            afe_trial    <= '0;
        end else begin
            afe_conv_clk <= seq_clk;
            afe_sample   <= seq_sample;
            afe_trial    <= seq_trial;
        end
    end

    sas_conv_seq u_seq (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .launch   (launch),
        .abort    (abort),
        .div_sel  (opt_q[DIV_LSB +: 2]),
        .comp     (comp_s2_q),
        .busy     (seq_busy),
        .conv_clk (seq_clk),
        .sample   (seq_sample),
        .trial    (seq_trial),
        .done     (seq_done),
        .result   (seq_result)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_start_autoclr:
    assert property (seq_done && !start_wr1 |=> !start_q)
    else $error("start bit not cleared at end of conversion");

    a_start_swclr:
    assert property (start_wr0 |=> !start_q ##1 !seq_busy)
    else $error("zero write did not clear start bit");

    a_done_irq:
    assert property (seq_done && mask_q && !we_mask |=> done_flag_q && irq)
    else $error("completion did not raise flag and interrupt");

    a_flag_startclr:
    assert property (launch && !seq_done |=> !done_flag_q)
    else $error("start did not clear done flag");

    a_flag_efclr:
    assert property (we_interrupt_flags && wbyte_q == INTERRUPT_FLAGS_CLR_DONE && !seq_done
                     |=> !done_flag_q)
    else $error("writing EF did not clear done flag");

    a_result_load:
    assert property (seq_done |=> res_q == $past(seq_result))
    else $error("result not loaded at completion");

    a_result_hold:
    assert property (!seq_done |=> $stable(res_q))
    else $error("result changed without a completion");

    a_mux_reserved:
    assert property (!chan_legal(chan_code) |=> !afe_mux_en)
    else $error("reserved channel code left mux enabled");

    a_ref_follow:
    assert property (##1 afe_ref_bandgap == $past(chref_q[REF_BIT]))
    else $error("reference select does not follow register");
endmodule

// File: bench/sas_afe_model.sv
`timescale 1ns/100ps
module sas_afe_model (
    input  wire logic [sas_pkg::RES_W-1:0] trial,  // SAR trial code
    input  wire logic                      sample, // Track/hold phase
    input  wire logic [sas_pkg::RES_W-1:0] level,  // Held input level
    input  wire logic                      aclk,   // Clock
    output logic                           comp    // Comparator out
);
    logic tgl = 1'b0;

    // Output is meaningless while tracking, so it chatters then
    always @(posedge aclk) tgl <= ~tgl;
    assign comp = sample ? tgl : (trial <= level);
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import sas_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, irq, comp;
    logic        afe_conv_clk, afe_sample, afe_mux_en, afe_ref_bandgap;
    logic [11:0] awaddr, araddr, afe_trial, level;
    logic [31:0] wdata, rdata, rval, old;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, afe_bg_level, wrsp, rrsp;
    logic [4:0]  afe_channel;
    int          err_count, check_count;

    sas_top DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq), .afe_comp(comp), .afe_conv_clk(afe_conv_clk),
        .afe_sample(afe_sample), .afe_trial(afe_trial),
        .afe_channel(afe_channel), .afe_mux_en(afe_mux_en),
        .afe_ref_bandgap(afe_ref_bandgap), .afe_bg_level(afe_bg_level)
    );
    sas_afe_model AFE (.trial(afe_trial), .sample(afe_sample),
                       .level(level), .aclk(aclk), .comp(comp));

    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction

    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic tmo();
        err_count++;
        $display("Error bus_wait expected answer seen none");
        summarize();
    endtask

    // Ready sampled at the edge; payload held until then
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        wrsp = bresp;
        if (n >= 50) tmo();
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rval = rdata;
        rrsp = rresp;
        if (n >= 50) tmo();
    endtask

    task automatic t_regs();
        rd(ba(IDX_OPTION));
        chk("option_rst", 32'h00, rval);
        rd(ba(IDX_CHREF));
        chk("chref_rst", 32'hf8, rval);
        chk("chan_rst", 5'h1f, afe_channel);
        chk("mux_rst", 1'b0, afe_mux_en);
        rd(12'h004);
        chk("unmapped_rresp", 2'b10, rrsp);
        wr(12'h004, 8'hff);
        chk("unmapped_bresp", 2'b10, wrsp);
        wr(ba(IDX_RES_HI), 8'hff);
        rd(ba(IDX_RES_HI));
        chk("result_ro", 32'h00, rval);
        $display("t_regs done");
    endtask

    task automatic t_chan();
        logic [4:0] c [7] = '{5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h15,
                              5'h16, 5'h17};
        logic       rf;
        logic [1:0] bg;
        for (int i = 0; i < 7; i++) begin
            rf = i[0];
            bg = rf ? 2'b01 : i[2:1];
            wr(ba(IDX_CHREF), {c[i], rf, bg});
            repeat (2) @(posedge aclk);
            chk("channel", c[i], afe_channel);
            chk("mux_en", c[i] != 5'h16, afe_mux_en);
            chk("ref_bg", rf, afe_ref_bandgap);
            chk("bg_level", bg == 2'b01, afe_bg_level);
        end
        $display("t_chan done");
    endtask

    task automatic t_conv(input logic [1:0] ks, input logic [11:0] lv,
                          input logic m);
        int d;
        int n;
        int rises;
        int samp;
        logic prev;
        d = 32 >> ks;
        n = 0;
        rises = 0;
        samp = 0;
        prev = 1'b0;
        level <= lv;
        wr(ba(IDX_EVT_STAT), 8'h01);
        wr(ba(IDX_EVT_MASK), {7'h00, m});
        wr(ba(IDX_OPTION), {4'h0, ks, 2'b00});
        wr(ba(IDX_AUXILIARY_CONTROL_ONE), 8'h10);
        // Converter clock must idle low, so only this run's pulses count
        while (irq !== 1'b1 && n < 42 * d + 8) begin
            @(posedge aclk);
            n++;
            if (afe_conv_clk === 1'b1 && prev !== 1'b1) rises++;
            if (afe_sample === 1'b1) samp++;
            prev = afe_conv_clk;
        end
        chk("conv_clk_pulses", 42, rises);
        chk("sample_cycles", (42 - 2 * 12) * d, samp);
        if (m) chk("cycles", 1, n >= 42*d-4 && n <= 42*d+6);
        else chk("masked_irq", 42 * d + 8, n);
        rd(ba(IDX_RES_HI));
        chk("result_high", lv[11:4], rval);
        rd(ba(IDX_RES_LO));
        chk("result_low", {lv[3:0], 4'h0}, rval);
        rd(ba(IDX_AUXILIARY_CONTROL_ONE));
        chk("start_auto_clr", 32'h00, rval);
        rd(ba(IDX_INTERRUPT_FLAGS));
        chk("done_flag", 32'h10, rval);
        chk("irq", m, irq);
        $display("t_conv done, divide by %0d", d);
    endtask

    task automatic t_abort();
        rd(ba(IDX_RES_HI));
        old = rval;
        level <= 12'h5a3;
        wr(ba(IDX_AUXILIARY_CONTROL_ONE), 8'h10);
        rd(ba(IDX_INTERRUPT_FLAGS));
        chk("flag_on_start", 32'h00, rval);
        rd(ba(IDX_AUXILIARY_CONTROL_ONE));
        chk("start_busy", 32'h10, rval);
        rd(ba(IDX_EVT_STAT));
        chk("evt_busy", 32'h03, rval);
        wr(ba(IDX_AUXILIARY_CONTROL_ONE), 8'h00);
        rd(ba(IDX_AUXILIARY_CONTROL_ONE));
        chk("start_zero", 32'h00, rval);
        repeat (200) @(posedge aclk);
        rd(ba(IDX_RES_HI));
        chk("result_kept", old, rval);
        rd(ba(IDX_INTERRUPT_FLAGS));
        chk("abort_flag", 32'h00, rval);
        $display("t_abort done");
    endtask

    task automatic t_clear();
        wr(ba(IDX_INTERRUPT_FLAGS), 8'hff);
        rd(ba(IDX_INTERRUPT_FLAGS));
        chk("flag_w1", 32'h10, rval);
        wr(ba(IDX_INTERRUPT_FLAGS), INTERRUPT_FLAGS_CLR_DONE);
        rd(ba(IDX_INTERRUPT_FLAGS));
        chk("flag_ef", 32'h00, rval);
        $display("t_clear done");
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid} = 4'h0;
        {bready, rready, wstrb} = 6'h3f;
        {awaddr, araddr, level, wdata} = '0;
        err_count = 0;
        check_count = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_chan();
        t_conv(2'b00, 12'h001, 1'b1);
        t_conv(2'b01, 12'hfff, 1'b1);
        t_conv(2'b10, 12'h3c1, 1'b1);
        t_conv(2'b11, 12'ha5c, 1'b0);
        t_abort();
        t_conv(2'b11, 12'h7e0, 1'b0);
        t_clear();
        summarize();
    end
endmodule
